// ==== hdl/cvdac_regs.vh ====
// Register offsets, field positions and timing counts for the converter control block
`ifndef CVDAC_REGS_VH
`define CVDAC_REGS_VH
`define CVDAC_AW 12
`define CVDAC_LEG_RES0L 12'h09b
`define CVDAC_LEG_RES0H 12'h09c
`define CVDAC_LEG_CTL0 12'h09d
`define CVDAC_LEG_CTL1 12'h09e
`define CVDAC_LEG_CTL2 12'h09f
`define CVDAC_C1_CTL0 12'h711
`define CVDAC_C1_CTL1 12'h712
`define CVDAC_C1_CTL2 12'h713
`define CVDAC_C1_CTL3 12'h714
`define CVDAC_C1_STAT 12'h715
`define CVDAC_C1_PRE 12'h716
`define CVDAC_C1_ACQ 12'h717
`define CVDAC_C1_GRD 12'h718
`define CVDAC_C1_CAP 12'h719
`define CVDAC_C1_RES0L 12'h71a
`define CVDAC_C1_RES0H 12'h71b
`define CVDAC_C1_RES1L 12'h71c
`define CVDAC_C1_RES1H 12'h71d
`define CVDAC_C1_SEC 12'h71e
`define CVDAC_C2_CTL0 12'h791
`define CVDAC_C2_CTL3 12'h794
`define CVDAC_C2_RES0L 12'h79a
`define CVDAC_C2_RES0H 12'h79b
`define CVDAC_C2_RES1L 12'h79c
`define CVDAC_C2_RES1H 12'h79d
`define CVDAC_ON_BIT 0
`define CVDAC_GO_BIT 1
`define CVDAC_SEL_LSB 2
`define CVDAC_SEL_MSB 6
`define CVDAC_SYNC_BIT 2
`define CVDAC_FMT_BIT 7
`define CVDAC_CLK_LSB 4
`define CVDAC_CLK_MSB 6
`define CVDAC_TRIG_LSB 4
`define CVDAC_TRIG_MSB 6
`define CVDAC_DSEN_BIT 0
`define CVDAC_CTL_RESET 8'h00
`define CVDAC_CTL1_MASK 8'hf3
`define CVDAC_CTL2_MASK 8'h70
`define CVDAC_SEC_MASK 8'h7f
`define CVDAC_CTL3_MASK 8'h01
`define CVDAC_RES_BITS 10
`define CVDAC_FOSC_MHZ 50
`define CVDAC_INSTR_NS 80
`define CVDAC_INSTR_CYC ((`CVDAC_INSTR_NS * `CVDAC_FOSC_MHZ + 999) / 1000)
`define CVDAC_GAP_TAD 2
`define CVDAC_RC_DIV 7'd8
`endif

// ==== hdl/cvdac_top.v ====
// Control and register map for two converters with capacitive-divider sequencing
//
// The address-and-strobe port was left to the implementer.
`include "cvdac_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module cvdac_top (
   input wire CLK_SYS_I, // System clock, 50 MHz
   input wire RST_I, // Synchronous reset, active high
   input wire [`CVDAC_AW-1:0] ADDR_I, // Register address
   input wire [7:0] WDATA_I, // Write data
   input wire WR_I, // Write strobe
   input wire RD_I, // Read strobe
   output reg [7:0] RDATA_O, // Read data, cycle after strobe
   input wire [9:0] CONV1_SAMPLE_I, // Converter 1 comparator decisions
   input wire [9:0] CONV2_SAMPLE_I, // Converter 2 comparator decisions
   input wire [1:0] SPECIAL_TRIG_I, // Special event trigger pulse per converter
   input wire [1:0] FLAG_CLR_I, // Clear pulse for finished flags
   output reg [1:0] CONVERTER_FINISHED_FLAG_O, // Sticky finished flags
   output wire [1:0] POWER_ON_O, // Converter powered
   output wire [31:0] CONV1_MUX_O, // Converter 1 one-hot input connection
   output wire [31:0] CONV2_MUX_O, // Converter 2 one-hot input connection
   output wire [6:0] CONV1_SEC_MUX_O, // Converter 1 secondary connections
   output wire [1:0] CONVERTING_O // Conversion engine active
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_CONV = 2'd2;
   localparam ST_GAP = 2'd3;

   // One-hot connect vector for a select code; reserved codes give zero
   function [31:0] mux_decode;
      input conv2;
      input [4:0] code;
      input on;
      reg ok;
      begin
         ok = 1'b0;
         if (code <= 5'h02) begin
            ok = 1'b1;
         end else if (!conv2) begin
            ok = (code >= 5'h0a && code <= 5'h10) || code == 5'h1b || code == 5'h1d || code == 5'h1f;
         end else begin
            ok = (code == 5'h14);
         end
         mux_decode = (ok && on) ? (32'h0000_0001 << code) : 32'h0000_0000;
      end
   endfunction

   // Unconverted bits copy the last converted bit
   function [9:0] fill_partial;
      input [9:0] sar;
      input [3:0] pos;
      integer k;
      reg last;
      begin
         fill_partial = sar;
         last = (pos == 4'd9) ? 1'b0 : sar[pos+1];
         for (k = 0; k < 10; k = k + 1) begin
            if (k <= pos) begin
               fill_partial[k] = last;
            end
         end
      end
   endfunction

   // Result justified into a high/low pair at load time
   function [15:0] justify;
      input [9:0] r;
      input right;
      begin
         justify = right ? {6'h00, r} : {r, 6'h00};
      end
   endfunction

   // Register hit at either of its two addresses
   function reg_hit;
      input [`CVDAC_AW-1:0] a;
      input [`CVDAC_AW-1:0] ext;
      input [`CVDAC_AW-1:0] leg;
      begin
         reg_hit = (a == ext) || (a == leg);
      end
   endfunction

   reg [7:0] ctl1;
   reg [7:0] ctl2;
   reg [7:0] pre_time;
   reg [7:0] acq_time;
   reg [7:0] grd_drive;
   reg [7:0] cap_sel;
   reg [7:0] sec_sel;
   reg [5:0] div_cnt;
   reg [6:0] div_len;
   wire tad;
   wire rc_clk;
   wire sync_go;
   wire [1:0] busy;
   wire [1:0] on_bit;
   wire [15:0] res0 [0:1];
   wire [15:0] res1 [0:1];
   wire [7:0] ctl0_rd [0:1];
   wire [7:0] ctl3_rd [0:1];
   wire [7:0] stat_rd [0:1];
   wire [1:0] fin_all;

   assign rc_clk = (ctl1[`CVDAC_CLK_MSB-1:`CVDAC_CLK_LSB] == 2'b11);
   assign sync_go = WR_I && reg_hit(ADDR_I, `CVDAC_C1_CTL1, `CVDAC_LEG_CTL1) &&
      WDATA_I[`CVDAC_SYNC_BIT];

   // Conversion clock divider
   always @* begin
      case (ctl1[`CVDAC_CLK_MSB:`CVDAC_CLK_LSB])
         3'b000: div_len = 7'd2;
         3'b001: div_len = 7'd8;
         3'b010: div_len = 7'd32;
         3'b100: div_len = 7'd4;
         3'b101: div_len = 7'd16;
         3'b110: div_len = 7'd64;
         default: div_len = `CVDAC_RC_DIV;
      endcase
   end

   // Tick phase runs free, so the first decision may land up to one tick after ST_CONV is entered
   assign tad = ({1'b0, div_cnt} == div_len - 7'd1);

   always @(posedge CLK_SYS_I) begin
      if (RST_I || tad) begin
         div_cnt <= 6'h00;
      end else begin
         div_cnt <= div_cnt + 6'h01;
      end
   end

   // Shared control and extended-only registers; legacy addresses alias the same flops
   always @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         ctl1 <= `CVDAC_CTL_RESET;
         ctl2 <= `CVDAC_CTL_RESET;
         pre_time <= `CVDAC_CTL_RESET;
         acq_time <= `CVDAC_CTL_RESET;
         grd_drive <= `CVDAC_CTL_RESET;
         cap_sel <= `CVDAC_CTL_RESET;
         sec_sel <= `CVDAC_CTL_RESET;
      end else if (WR_I) begin
         case (ADDR_I)
            `CVDAC_C1_CTL1, `CVDAC_LEG_CTL1: ctl1 <= WDATA_I & `CVDAC_CTL1_MASK;
            `CVDAC_C1_CTL2, `CVDAC_LEG_CTL2: ctl2 <= WDATA_I & `CVDAC_CTL2_MASK;
            `CVDAC_C1_PRE: pre_time <= WDATA_I;
            `CVDAC_C1_ACQ: acq_time <= WDATA_I;
            `CVDAC_C1_GRD: grd_drive <= WDATA_I;
            `CVDAC_C1_CAP: cap_sel <= WDATA_I;
            `CVDAC_C1_SEC: sec_sel <= WDATA_I & `CVDAC_SEC_MASK;
            default: ctl1 <= ctl1;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : conv
         reg [6:0] ctl0; // Select field and enable; status bit comes from the engine
         reg dsen;
         reg [1:0] state;
         reg second;
         reg [3:0] pos;
         reg [2:0] wcnt;
         reg [9:0] sar;
         reg [15:0] r0;
         reg [15:0] r1;
         wire ctl0_hit;
         wire ctl3_hit;
         wire [9:0] sample;
         wire user_go;
         wire user_stop;
         wire start;
         wire fmt;
         wire ctl0_wr;
         wire kill;
         wire last_tick;
         wire [9:0] partial;
         wire [15:0] full_word;
         reg fin;

         if (g == 0) begin : a1
            assign ctl0_hit = reg_hit(ADDR_I, `CVDAC_C1_CTL0, `CVDAC_LEG_CTL0);
            assign ctl3_hit = (ADDR_I == `CVDAC_C1_CTL3);
            assign sample = CONV1_SAMPLE_I;
         end else begin : a2
            assign ctl0_hit = (ADDR_I == `CVDAC_C2_CTL0);
            assign ctl3_hit = (ADDR_I == `CVDAC_C2_CTL3);
            assign sample = CONV2_SAMPLE_I;
         end

         assign fmt = ctl1[`CVDAC_FMT_BIT];
         assign user_go = WR_I && ctl0_hit && WDATA_I[`CVDAC_GO_BIT] && ctl0[`CVDAC_ON_BIT];
         assign user_stop = WR_I && ctl0_hit && !WDATA_I[`CVDAC_GO_BIT];
         assign start = user_go || (sync_go && ctl0[`CVDAC_ON_BIT]) ||
            (SPECIAL_TRIG_I[g] && ctl0[`CVDAC_ON_BIT] && ctl2[`CVDAC_TRIG_MSB:`CVDAC_TRIG_LSB] != 3'b000);
         assign ctl0_wr = WR_I && ctl0_hit;
         // Enable cleared mid-run drops the bits done so far, unlike an abort
         assign kill = !ctl0[`CVDAC_ON_BIT] || (ctl0_wr && !WDATA_I[`CVDAC_ON_BIT]);
         assign partial = fill_partial(sar, pos);
         assign full_word = justify({sar[9:1], sample[0]}, fmt);
         assign last_tick = (state == ST_CONV) && tad && (pos == 4'd0) && !kill && !user_stop &&
            !(dsen && !second);

         always @(posedge CLK_SYS_I) begin
            if (RST_I) begin
               ctl0 <= 7'h00;
               dsen <= 1'b0;
            end else if (WR_I && ctl0_hit) begin
               ctl0 <= {WDATA_I[`CVDAC_SEL_MSB:`CVDAC_SEL_LSB], 1'b0, WDATA_I[`CVDAC_ON_BIT]};
            end else if (WR_I && ctl3_hit) begin
               dsen <= WDATA_I[`CVDAC_DSEN_BIT];
            end
         end

         // Conversion engine: one comparator decision per conversion clock, MSB first
         always @(posedge CLK_SYS_I) begin
            if (RST_I) begin
               state <= ST_IDLE;
               second <= 1'b0;
               pos <= 4'd9;
               wcnt <= 3'd0;
               sar <= 10'h000;
               r0 <= 16'h0000;
               r1 <= 16'h0000;
            end else begin
               if (state == ST_IDLE) begin
                  if (start) begin
                     second <= 1'b0;
                     pos <= 4'd9;
                     sar <= 10'h000;
                     wcnt <= 3'd0;
                     state <= rc_clk ? ST_WAIT : ST_CONV;
                  end
               end else if (kill) begin
                  state <= ST_IDLE;
               end else if (user_stop) begin
                  // Abort keeps the bits done so far, no flag
                  if (second) begin
                     r1 <= justify(partial, fmt);
                  end else begin
                     r0 <= justify(partial, fmt);
                  end
                  state <= ST_IDLE;
               end else begin
                  case (state)
                     ST_WAIT: begin
                        if (wcnt == `CVDAC_INSTR_CYC - 1) begin
                           state <= ST_CONV;
                        end else begin
                           wcnt <= wcnt + 3'd1;
                        end
                     end
                     ST_CONV: begin
                        if (tad) begin
                           sar[pos] <= sample[pos];
                           if (pos == 4'd0) begin
                              if (!second) begin
                                 r0 <= full_word;
                              end else begin
                                 r1 <= full_word;
                              end
                              if (dsen && !second) begin
                                 state <= ST_GAP;
                                 wcnt <= 3'd0;
                              end else begin
                                 state <= ST_IDLE;
                              end
                           end else begin
                              pos <= pos - 4'd1;
                           end
                        end
                     end
                     ST_GAP: begin
                        if (tad) begin
                           if (wcnt == `CVDAC_GAP_TAD - 1) begin
                              state <= ST_CONV;
                              second <= 1'b1;
                              pos <= 4'd9;
                              sar <= 10'h000;
                           end else begin
                              wcnt <= wcnt + 3'd1;
                           end
                        end
                     end
                     default: state <= ST_IDLE;
                  endcase
               end
            end
         end

         // Completion wins over a clear pulse in the same cycle
         always @(posedge CLK_SYS_I) begin
            if (RST_I) begin
               fin <= 1'b0;
            end else if (last_tick) begin
               fin <= 1'b1;
            end else if (FLAG_CLR_I[g]) begin
               fin <= 1'b0;
            end
         end

         assign fin_all[g] = fin;
         assign busy[g] = (state != ST_IDLE) && ctl0[`CVDAC_ON_BIT];
         assign on_bit[g] = ctl0[`CVDAC_ON_BIT];
         assign res0[g] = r0;
         assign res1[g] = r1;
         assign ctl0_rd[g] = {1'b0, ctl0[6:2], busy[g], ctl0[0]};
         assign ctl3_rd[g] = {7'h00, dsen};
         assign stat_rd[g] = {4'h0, second, 1'b0, state};
      end
   endgenerate

   // Flags live per converter; gathered here so the port has a single driver
   always @* begin
      CONVERTER_FINISHED_FLAG_O = fin_all;
   end

   assign POWER_ON_O = on_bit;
   assign CONVERTING_O = busy;
   assign CONV1_MUX_O = mux_decode(1'b0, ctl0_rd[0][6:2], on_bit[0]);
   assign CONV2_MUX_O = mux_decode(1'b1, ctl0_rd[1][6:2], on_bit[1]);
   // Secondary switches close only while converter 1 is enabled
   assign CONV1_SEC_MUX_O = on_bit[0] ? sec_sel[6:0] : 7'h00;

   // Read data stand only in the cycle after the strobe
   always @(posedge CLK_SYS_I) begin
      if (RST_I || !RD_I) begin
         RDATA_O <= 8'h00;
      end else begin
         case (ADDR_I)
            `CVDAC_C1_CTL0, `CVDAC_LEG_CTL0: RDATA_O <= ctl0_rd[0];
            `CVDAC_C1_CTL1, `CVDAC_LEG_CTL1: RDATA_O <= {ctl1[7:3], |busy, ctl1[1:0]};
            `CVDAC_C1_CTL2, `CVDAC_LEG_CTL2: RDATA_O <= ctl2;
            `CVDAC_C1_CTL3: RDATA_O <= ctl3_rd[0];
            `CVDAC_C1_STAT: RDATA_O <= stat_rd[0];
            `CVDAC_C1_PRE: RDATA_O <= pre_time;
            `CVDAC_C1_ACQ: RDATA_O <= acq_time;
            `CVDAC_C1_GRD: RDATA_O <= grd_drive;
            `CVDAC_C1_CAP: RDATA_O <= cap_sel;
            `CVDAC_C1_RES0L, `CVDAC_LEG_RES0L: RDATA_O <= res0[0][7:0];
            `CVDAC_C1_RES0H, `CVDAC_LEG_RES0H: RDATA_O <= res0[0][15:8];
            `CVDAC_C1_RES1L: RDATA_O <= res1[0][7:0];
            `CVDAC_C1_RES1H: RDATA_O <= res1[0][15:8];
            `CVDAC_C1_SEC: RDATA_O <= sec_sel;
            `CVDAC_C2_CTL0: RDATA_O <= ctl0_rd[1];
            `CVDAC_C2_CTL3: RDATA_O <= ctl3_rd[1];
            `CVDAC_C2_RES0L: RDATA_O <= res0[1][7:0];
            `CVDAC_C2_RES0H: RDATA_O <= res0[1][15:8];
            `CVDAC_C2_RES1L: RDATA_O <= res1[1][7:0];
            `CVDAC_C2_RES1H: RDATA_O <= res1[1][15:8];
            default: RDATA_O <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== verif/cvdac_top_assertions.sv ====
// Port-level checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "cvdac_regs.vh"
module cvdac_top_chk (
   input wire CLK_SYS_I, // Clock
   input wire RST_I, // Reset
   input wire [`CVDAC_AW-1:0] ADDR_I, // Address
   input wire [7:0] WDATA_I, // Write data
   input wire WR_I, // Write strobe
   input wire [1:0] CONVERTER_FINISHED_FLAG_O, // Flags
   input wire [1:0] POWER_ON_O, // Enables
   input wire [31:0] CONV1_MUX_O, // Mux 1
   input wire [31:0] CONV2_MUX_O, // Mux 2
   input wire [6:0] CONV1_SEC_MUX_O, // Secondary
   input wire [1:0] CONVERTING_O // Busy
);
   localparam logic [31:0] OK1 = 32'ha801fc07;
   localparam logic [31:0] OK2 = 32'h00100007;
   wire c0w = WR_I && (ADDR_I == `CVDAC_C1_CTL0 || ADDR_I == `CVDAC_LEG_CTL0);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   off_disc_a: assert property (!POWER_ON_O[0] |-> CONV1_MUX_O == 32'h0 && CONV1_SEC_MUX_O == 7'h0)
      else $error("Converter 1 input closed while off");
   code_map1_a: assert property ((CONV1_MUX_O & ~OK1) == 32'h0 && $onehot0(CONV1_MUX_O))
      else $error("Converter 1 reserved or multiple input");
   code_map2_a: assert property ((CONV2_MUX_O & ~OK2) == 32'h0 && (POWER_ON_O[1] || CONV2_MUX_O == 32'h0))
      else $error("Converter 2 bad input connection");
   power_wr_a: assert property (c0w |=> POWER_ON_O[0] == $past(WDATA_I[0]))
      else $error("Enable does not follow write");
   start_wr_a: assert property (c0w && WDATA_I[1:0] == 2'b11 && POWER_ON_O[0] && !CONVERTING_O[0] |=> CONVERTING_O[0])
      else $error("Start write ignored");
   abort_wr_a: assert property (c0w && WDATA_I[1:0] == 2'b01 && CONVERTING_O[0] |=>
      !CONVERTING_O[0] && !$rose(CONVERTER_FINISHED_FLAG_O[0]))
      else $error("Abort did not stop cleanly");
   off_idle_a: assert property (!POWER_ON_O[0] |-> !CONVERTING_O[0])
      else $error("Busy while disabled");
   flag_src_a: assert property ($rose(CONVERTER_FINISHED_FLAG_O[0]) |->
      $past(CONVERTING_O[0]) || $past(CONVERTING_O[0], 2))
      else $error("Flag set without conversion");
   sync_go_a: assert property (WR_I && ADDR_I == `CVDAC_C1_CTL1 && WDATA_I[2] && POWER_ON_O[0] && !CONVERTING_O[0]
      |=> CONVERTING_O[0])
      else $error("Synchronized start ignored");
   // Slowest double conversion stays under 1500 system cycles
   logic [11:0] run_len;
   always @(posedge CLK_SYS_I) begin
      if (RST_I || !CONVERTING_O[0]) begin
         run_len <= 12'h000;
      end else begin
         run_len <= run_len + 12'h001;
      end
   end
   run_end_a: assert property (run_len < 12'd1600)
      else $error("Conversion never ends");
   cover property ($rose(CONVERTER_FINISHED_FLAG_O[0]));
   cover property (c0w && WDATA_I[1:0] == 2'b01 && CONVERTING_O[0]);
   cover property (CONVERTING_O == 2'b11);
endmodule
bind cvdac_top cvdac_top_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WR_I(WR_I), .CONVERTER_FINISHED_FLAG_O(CONVERTER_FINISHED_FLAG_O), .POWER_ON_O(POWER_ON_O),
   .CONV1_MUX_O(CONV1_MUX_O), .CONV2_MUX_O(CONV2_MUX_O), .CONV1_SEC_MUX_O(CONV1_SEC_MUX_O),
   .CONVERTING_O(CONVERTING_O));
`default_nettype wire

// ==== verif/cvd_adc_control_map_tb_top.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "cvdac_regs.vh"
module cvd_adc_control_map_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [`CVDAC_AW-1:0] addr = '0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [9:0] s1 = 10'h000;
   logic [9:0] s2 = 10'h000;
   logic [1:0] trig = 2'h0;
   logic [1:0] fclr = 2'h0;
   wire [7:0] rdata;
   wire [1:0] flag;
   wire [1:0] pwr;
   wire [1:0] busy;
   wire [31:0] mux1;
   wire [31:0] mux2;
   wire [6:0] sec;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   localparam logic [31:0] OK1 = 32'ha801fc07;
   localparam logic [31:0] OK2 = 32'h00100007;
   always #10 clk = ~clk;
   cvdac_top u_cvdac_top (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .CONV1_SAMPLE_I(s1), .CONV2_SAMPLE_I(s2), .SPECIAL_TRIG_I(trig), .FLAG_CLR_I(fclr),
      .CONVERTER_FINISHED_FLAG_O(flag), .POWER_ON_O(pwr), .CONV1_MUX_O(mux1), .CONV2_MUX_O(mux2),
      .CONV1_SEC_MUX_O(sec), .CONVERTING_O(busy));
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Whole run needs several hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fails++;
         final_report;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrr(input logic [`CVDAC_AW-1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rdv(input logic [`CVDAC_AW-1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rdc(input logic [`CVDAC_AW-1:0] a, input logic [7:0] e);
      logic [7:0] d;
      rdv(a, d);
      chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, d});
   endtask
   task automatic idle(input int b);
      int n;
      n = 0;
      while (busy[b] !== 1'b0 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("conversion end", 32'h0, {31'h0, busy[b]});
   endtask
   task automatic clr;
      @(posedge clk);
      fclr <= 2'h3;
      @(posedge clk);
      fclr <= 2'h0;
      #1;
      chk("flag clear", 32'h0, {30'h0, flag});
   endtask
   task automatic t_reset;
      rdc(`CVDAC_C1_CTL0, 8'h00);
      rdc(`CVDAC_C2_CTL0, 8'h00);
      rdc(`CVDAC_LEG_RES0L, 8'h00);
      chk("power", 32'h0, {30'h0, pwr});
   endtask
   task automatic t_map;
      wrr(`CVDAC_C1_CTL0, 8'hfc);
      rdc(`CVDAC_LEG_CTL0, 8'h7c);
      wrr(`CVDAC_LEG_CTL2, 8'hff);
      rdc(`CVDAC_C1_CTL2, 8'h70);
      wrr(`CVDAC_C1_CTL2, 8'h00);
      wrr(`CVDAC_C1_SEC, 8'hff);
      rdc(`CVDAC_C1_SEC, 8'h7f);
      chk("secondary off", 32'h0, {25'h0, sec});
      wrr(`CVDAC_C1_CTL0, 8'h01);
      chk("secondary on", 32'h7f, {25'h0, sec});
      wrr(`CVDAC_C1_SEC, 8'h00);
      rdc(12'h700, 8'h00);
   endtask
   task automatic t_mux;
      logic [31:0] e;
      for (int c = 0; c < 32; c++) begin
         wrr(`CVDAC_C1_CTL0, {1'b0, c[4:0], 2'b01});
         e = OK1[c] ? 32'h1 << c : 32'h0;
         chk("input mux 1", e, mux1);
         rdc(`CVDAC_C1_CTL0, {1'b0, c[4:0], 2'b01});
         wrr(`CVDAC_C2_CTL0, {1'b0, c[4:0], 2'b01});
         e = OK2[c] ? 32'h1 << c : 32'h0;
         chk("input mux 2", e, mux2);
         wrr(`CVDAC_C1_CTL0, {1'b0, c[4:0], 2'b00});
         chk("mux off", 32'h0, mux1);
      end
      wrr(`CVDAC_C2_CTL0, 8'h00);
   endtask
   task automatic t_conv;
      @(posedge clk);
      s1 <= 10'h2b5;
      wrr(`CVDAC_C1_CTL1, 8'h80);
      wrr(`CVDAC_C1_CTL0, 8'h03);
      chk("start while off", 32'h0, {31'h0, busy[0]});
      chk("power on", 32'h1, {30'h0, pwr});
      wrr(`CVDAC_C1_CTL0, 8'h03);
      rdc(`CVDAC_C1_CTL0, 8'h03);
      idle(0);
      rdc(`CVDAC_C1_CTL0, 8'h01);
      chk("finished flag", 32'h1, {31'h0, flag[0]});
      rdc(`CVDAC_C1_RES0L, 8'hb5);
      rdc(`CVDAC_LEG_RES0H, 8'h02);
      clr;
   endtask
   task automatic t_sync;
      @(posedge clk);
      s2 <= 10'h3c6;
      wrr(`CVDAC_C2_CTL0, 8'h01);
      wrr(`CVDAC_C1_CTL1, 8'hb4);
      chk("both busy", 32'h3, {30'h0, busy});
      rdc(`CVDAC_C1_CTL1, 8'hb4);
      idle(0);
      idle(1);
      chk("finished flags", 32'h3, {30'h0, flag});
      rdc(`CVDAC_C2_RES0H, 8'h03);
      rdc(`CVDAC_C2_RES0L, 8'hc6);
      rdc(`CVDAC_LEG_CTL1, 8'hb0);
      clr;
   endtask
   task automatic t_double;
      logic [7:0] d;
      int n;
      n = 0;
      // Sensed node parked low before the differential pair
      @(posedge clk);
      s1 <= 10'h000;
      @(posedge clk);
      s1 <= 10'h155;
      wrr(`CVDAC_C1_CTL1, 8'hc0);
      wrr(`CVDAC_C1_CTL3, 8'h01);
      wrr(`CVDAC_C1_CTL0, 8'h03);
      do begin
         rdv(`CVDAC_C1_RES0L, d);
         n++;
      end while (d !== 8'h55 && n < 200);
      chk("first pair", 32'h55, {24'h0, d});
      chk("busy between", 32'h1, {31'h0, busy[0]});
      chk("no flag between", 32'h0, {31'h0, flag[0]});
      @(posedge clk);
      s1 <= 10'h0aa;
      idle(0);
      rdc(`CVDAC_C1_RES0H, 8'h01);
      rdc(`CVDAC_C1_RES1L, 8'haa);
      rdc(`CVDAC_C1_RES1H, 8'h00);
      wrr(`CVDAC_C1_CTL3, 8'h00);
      clr;
   endtask
   task automatic t_abort;
      @(posedge clk);
      s1 <= 10'h3ff;
      wrr(`CVDAC_C1_CTL0, 8'h03);
      // Long enough for a few bits, far short of ten
      repeat (10) @(posedge clk);
      wrr(`CVDAC_C1_CTL0, 8'h01);
      chk("abort busy", 32'h0, {31'h0, busy[0]});
      repeat (4) @(posedge clk);
      chk("abort flag", 32'h0, {31'h0, flag[0]});
      rdc(`CVDAC_C1_RES0L, 8'hff);
      rdc(`CVDAC_C1_RES0H, 8'h03);
   endtask
   task automatic t_trig;
      wrr(`CVDAC_C1_CTL2, 8'h30);
      @(posedge clk);
      trig <= 2'h1;
      @(posedge clk);
      trig <= 2'h0;
      repeat (2) @(posedge clk);
      #1;
      chk("trigger start", 32'h1, {31'h0, busy[0]});
      wrr(`CVDAC_C1_CTL0, 8'h00);
      chk("disable stop", 32'h0, {31'h0, busy[0]});
      chk("disable mux", 32'h0, mux1);
      wrr(`CVDAC_C1_CTL2, 8'h00);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_map;
      t_mux;
      t_conv;
      t_sync;
      t_double;
      t_abort;
      t_trig;
      final_report;
   end
endmodule
`default_nettype wire
